// >>> awc_chk.sv
`timescale 1ns/1ns
`default_nettype none
module awc_chk import awc_pkg::*; #(
  parameter int unsigned NUM_ALARM  = 8,
  parameter int unsigned NUM_WARN   = 8,
  parameter int unsigned NOTIFY_LAG = 4
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ext_alarm_clear_in,
  input  wire logic [NUM_ALARM-1:0] alarm_cause_i,
  input  wire awc_comm_err_t        comm_err_i,
  input  wire awc_map_req_t         map_req_i,
  input  wire logic                 map_ack_o,
  input  wire logic                 map_ok_o,
  input  wire awc_state_t           drive_state_o,
  input  wire logic [NUM_WARN-1:0]  warn_o,
  input  wire logic [7:0]           disp_num_o,
  input  wire logic                 disp_hold_o,
  input  wire logic                 clear_done_o,
  input  wire logic                 led_run_o,
  input  wire logic                 led_err_o,
  input  wire logic [3:0]           esm_state_o,
  input  wire logic [15:0]          al_status_o,
  input  wire logic                 alarm_active_o,
  input  wire logic                 al_notify_o
);
  // ==========================================================
  // Expected mapping answer and notification source
  logic ok_c;
  logic act_c;
  always_comb begin
    act_c = alarm_active_o | (|warn_o);
    ok_c = 1'b0;
    if (map_req_i.idx < 3'h5) begin
      ok_c = AWC_OBJ_PDO[map_req_i.idx][map_req_i.tx];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_from_fault;
    clear_done_o |-> $past(drive_state_o) == AWC_ST_FAULT;
  endproperty
  a_from_fault: assert property (p_from_fault)
    else $error("clear outside fault state");
  property p_no_cause;
    clear_done_o |-> $past(alarm_cause_i) == '0;
  endproperty
  a_no_cause: assert property (p_no_cause)
    else $error("clear with a cause active");
  property p_sod;
    drive_state_o == AWC_ST_SOD && $past(drive_state_o) == AWC_ST_FAULT
      |-> clear_done_o;
  endproperty
  a_sod: assert property (p_sod)
    else $error("fault left without clear");
  property p_freact;
    drive_state_o == AWC_ST_FREACT |=> drive_state_o != AWC_ST_SOD;
  endproperty
  a_freact: assert property (p_freact)
    else $error("clear during fault reaction");
  property p_pulse;
    clear_done_o |=> !clear_done_o;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("clear repeated on level");
  property p_warn;
    ext_alarm_clear_in [*4] |=> (warn_o & ~$past(warn_o)) == '0;
  endproperty
  a_warn: assert property (p_warn)
    else $error("warning raised while clear input on");
  property p_disp;
    disp_hold_o && !clear_done_o
      |=> clear_done_o || (disp_hold_o && $stable(disp_num_o));
  endproperty
  a_disp: assert property (p_disp)
    else $error("display number not held");
  property p_map;
    map_req_i.valid |=> map_ack_o && map_ok_o == $past(ok_c);
  endproperty
  a_map: assert property (p_map)
    else $error("mapping answer wrong");
  property p_comm;
    comm_err_i.valid |=> {led_run_o, led_err_o, esm_state_o, al_status_o}
      == $past(comm_err_i[21:0]);
  endproperty
  a_comm: assert property (p_comm)
    else $error("comm error status not refreshed");
  property p_notify;
    al_notify_o == $past(act_c, NOTIFY_LAG);
  endproperty
  a_notify: assert property (p_notify)
    else $error("status notification lag wrong");
endmodule
`default_nettype wire

// >>> awc_edge.sv
`timescale 1ns/1ns
`default_nettype none
module awc_edge import awc_pkg::*; #(
  parameter bit SYNC = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      level,
  output logic      rise
);

  // ==========================================================
  // Optional two-stage synchroniser
  logic meta_q;
  logic meta_d;
  logic samp_q;
  logic samp_d;
  logic prev_q;
  logic prev_d;
  logic src;

  generate
    if (SYNC) begin : g_sync
      assign src = samp_q;
    end else begin : g_direct
      assign src = din;
    end
  endgenerate

  always_comb begin
    meta_d = din;
    samp_d = meta_q;
    prev_d = src;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      samp_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      samp_q <= samp_d;
      prev_q <= prev_d;
    end
  end

  // ==========================================================
  // Edge output
  assign level = src;
  assign rise  = src & ~prev_q;

endmodule
`default_nettype wire

// >>> awc_master.sv
`timescale 1ns/1ns
`default_nettype none
module awc_master import awc_pkg::*; (
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  output var  logic        tmo
);
  // ==========================================================
  // Bus master side of the controller
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    tmo     = 1'b0;
  end

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      tmo <= 1'b1;
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Acknowledge first, then a low-to-high fault reset bit
  task automatic fault_reset;
    logic [31:0] r;
    logic        e;
    xfer(1'b1, AWC_OFS_CTRL, 32'h3, r, e);
    xfer(1'b1, AWC_OFS_CWORD, 32'h0, r, e);
    xfer(1'b1, AWC_OFS_CWORD, 32'h80, r, e);
  endtask
endmodule
`default_nettype wire

// >>> awc_pkg.sv
// Contract
// - Master sets ack, then fault-reset edge clears (warning clear needs no ack)
// - Completed clear with no unclearable alarm left moves Fault to switch-on-disabled
// - External clear input rising edge requests clear
// - External input held blocks bus and tool clears
// - No alarm clear during fault reaction
// - Clear refused while any alarm cause remains
// - First error number held; unclearable survives clear
// - Each communication error refreshes leds, state, status
// - Status notification lags the alarm or latched warning itself
// - Latched warnings persist until an accepted clear
// - No warning clear during fault reaction
// - External clear input active suppresses warnings
// - Object writes take effect per attribute code
// - Mapping accepted only for mappable objects
package awc_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned AWC_NUM_ALARM  = 8;
  localparam int unsigned AWC_NUM_WARN   = 8;
  localparam int unsigned AWC_NOTIFY_LAG = 4;
  localparam int unsigned AWC_NUM_OBJ    = 5;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] AWC_OFS_CTRL  = 8'h00;
  localparam logic [7:0] AWC_OFS_CWORD = 8'h04;
  localparam logic [7:0] AWC_OFS_TOOL  = 8'h08;
  localparam logic [7:0] AWC_OFS_STAT  = 8'h0c;
  localparam logic [7:0] AWC_OFS_ALARM = 8'h10;
  localparam logic [7:0] AWC_OFS_WARN  = 8'h14;
  localparam logic [7:0] AWC_OFS_DISP  = 8'h18;
  localparam logic [7:0] AWC_OFS_COMM  = 8'h1c;
  localparam logic [7:0] AWC_OFS_OBJ   = 8'h20;

  // ==========================================================
  // Field positions and reset values
  localparam int unsigned AWC_CTRL_ACK_BIT    = 0;
  localparam int unsigned AWC_CTRL_WLATCH_BIT = 1;
  localparam int unsigned AWC_TOOL_CLR_BIT    = 0;
  localparam int unsigned AWC_CW_FRESET_BIT   = 7;
  localparam logic [1:0]  AWC_CTRL_RST        = 2'h0;
  localparam logic [15:0] AWC_CWORD_RST       = 16'h0000;
  localparam logic [15:0] AWC_OBJ_RST         = 16'h0000;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    AWC_ST_SOD,
    AWC_ST_FREACT,
    AWC_ST_FAULT
  } awc_state_t;

  typedef enum logic [2:0] {
    AWC_ATTR_A,
    AWC_ATTR_R,
    AWC_ATTR_P,
    AWC_ATTR_S,
    AWC_ATTR_X
  } awc_attr_t;

  typedef struct packed {
    logic        valid;
    logic        run_led;
    logic        err_led;
    logic [3:0]  esm;
    logic [15:0] al_status;
  } awc_comm_err_t;

  typedef struct packed {
    logic       valid;
    logic       tx;
    logic [2:0] idx;
  } awc_map_req_t;

  // ==========================================================
  // Object table: attribute and mapping flags (bit0 rx, bit1 tx)
  localparam awc_attr_t AWC_OBJ_ATTR [AWC_NUM_OBJ] = '{
    AWC_ATTR_A, AWC_ATTR_R, AWC_ATTR_P, AWC_ATTR_S, AWC_ATTR_X
  };
  localparam logic [1:0] AWC_OBJ_PDO [AWC_NUM_OBJ] = '{
    2'h1, 2'h0, 2'h2, 2'h3, 2'h0
  };

endpackage

// >>> awc_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module awc_tb_top import awc_pkg::*; ;
  logic            clk, rst, psel, penable, pwrite, pready, pslverr;
  logic            ext, frd, pwr, ip, ps, tmo, er, dhold, lrun, lerr, aact;
  logic [7:0]      paddr, cause, unclr, warn_c, warn, dnum;
  logic [7:0][7:0] code;
  logic [31:0]     pwdata, prdata, rd;
  logic [3:0]      esm;
  logic [15:0]     als;
  awc_comm_err_t   cerr;
  awc_map_req_t    mreq;
  awc_state_t      st;
  int              n_mismatch;
  int              samples_checked;

  awc_top awc_top_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ext_alarm_clear_in(ext),
    .alarm_cause_i(cause), .alarm_unclr_i(unclr), .alarm_code_i(code),
    .fault_react_done_i(frd), .warn_cause_i(warn_c), .comm_err_i(cerr),
    .pwr_reset_evt_i(pwr), .esm_init_preop_i(ip), .esm_preop_safeop_i(ps),
    .map_req_i(mreq), .map_ack_o(), .map_ok_o(), .drive_state_o(st),
    .alarm_active_o(aact), .warn_o(warn), .disp_num_o(dnum),
    .disp_hold_o(dhold), .clear_done_o(), .led_run_o(lrun),
    .led_err_o(lerr), .esm_state_o(esm), .al_status_o(als),
    .al_notify_o());
  awc_master awc_master_i (.clk, .pready, .pslverr, .prdata, .psel,
    .penable, .pwrite, .paddr, .pwdata, .tmo);

  always #25 clk = ~clk;

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awc_master_i.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic to_fault(input logic [7:0] c, input logic e);
    @(posedge clk);
    cause <= c;
    ext   <= e;
    cyc(3);
    awc_master_i.fault_reset();
    cyc(3);
    chk(st, AWC_ST_FREACT);
    frd <= 1'b1;
    @(posedge clk);
    frd <= 1'b0;
    cyc(3);
    chk(st, AWC_ST_FAULT);
    chk(aact, 1'b1);
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_bus;
    to_fault(8'h01, 1'b0);
    cause <= 8'h00;
    wr(AWC_OFS_CTRL, 32'h0);
    wr(AWC_OFS_CWORD, 32'h0);
    wr(AWC_OFS_CWORD, 32'h80);
    cyc(3);
    chk(st, AWC_ST_FAULT);
    awc_master_i.fault_reset();
    cyc(3);
    chk(st, AWC_ST_SOD);
    chk(aact, 1'b0);
    to_fault(8'h01, 1'b0);
    awc_master_i.fault_reset();
    cyc(3);
    chk(st, AWC_ST_FAULT);
    cause <= 8'h00;
    wr(AWC_OFS_CWORD, 32'h80);
    cyc(3);
    chk(st, AWC_ST_FAULT);
    ext <= 1'b1;
    cyc(6);
    chk(st, AWC_ST_SOD);
    ext <= 1'b0;
  endtask
  task automatic s_ext;
    to_fault(8'h02, 1'b1);
    cause  <= 8'h00;
    warn_c <= 8'hff;
    awc_master_i.fault_reset();
    wr(AWC_OFS_TOOL, 32'h1);
    cyc(3);
    chk(st, AWC_ST_FAULT);
    chk(warn, 8'h00);
    warn_c <= 8'h00;
    cyc(1);
    ext <= 1'b0;
    cyc(4);
    wr(AWC_OFS_TOOL, 32'h1);
    cyc(3);
    chk(st, AWC_ST_SOD);
  endtask
  task automatic s_warn;
    wr(AWC_OFS_CTRL, 32'h3);
    warn_c <= 8'h05;
    cyc(3);
    warn_c <= 8'h00;
    cyc(3);
    chk(warn, 8'h05);
    to_fault(8'h01, 1'b0);
    chk(warn, 8'h05);
    cause <= 8'h00;
    awc_master_i.fault_reset();
    cyc(3);
    chk({st, warn}, {AWC_ST_SOD, 8'h00});
  endtask
  task automatic s_misc;
    logic [21:0] v;
    for (int i = 0; i < 2; i++) begin
      v = {i[0], ~i[0], 4'h3 + 4'(i), 16'ha0b0 ^ 16'(i)};
      cerr <= {1'b1, v};
      @(posedge clk);
      cerr.valid <= 1'b0;
      cyc(2);
      chk({lrun, lerr, esm, als}, v);
    end
    wr(AWC_OFS_OBJ + 8'h10, 32'h1);
    chk(er, 1'b1);
    wr(8'h40, 32'h0);
    chk(er, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(AWC_OFS_OBJ + 8'(4 * i), 32'h5a00 + i);
      awc_master_i.xfer(1'b0, AWC_OFS_OBJ + 8'(4 * i), 32'h0, rd, er);
      chk(rd, (i == 0) ? 32'h5a00 : 32'h0);
      {pwr, ip, ps} <= 3'(4'h8 >> i);
      @(posedge clk);
      {pwr, ip, ps} <= 3'h0;
      awc_master_i.xfer(1'b0, AWC_OFS_OBJ + 8'(4 * i), 32'h0, rd, er);
      chk(rd, 32'h5a00 + i);
    end
    for (int i = 0; i < 14; i++) begin
      mreq <= {1'b1, i[0], 3'(i >> 1)};
      @(posedge clk);
      mreq.valid <= 1'b0;
      cyc(1);
    end
  endtask
  task automatic s_disp;
    unclr <= 8'h08;
    to_fault(8'h0c, 1'b0);
    chk({dhold, dnum}, {1'b1, 8'h12});
    cause <= 8'h00;
    awc_master_i.fault_reset();
    cyc(3);
    chk({dhold, dnum}, {1'b1, 8'h12});
    awc_master_i.xfer(1'b0, AWC_OFS_STAT, 32'h0, rd, er);
    chk(rd, 32'h0000_000e);
  endtask

  always @(posedge clk) begin
    if (tmo === 1'b1) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    {clk, ext, frd, pwr, ip, ps, cause, unclr, warn_c} = '0;
    rst  = 1'b1;
    cerr = '0;
    mreq = '0;
    for (int i = 0; i < 8; i++) begin
      code[i] = 8'h10 + 8'(i);
    end
    n_mismatch      = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    s_bus();
    s_ext();
    s_warn();
    s_misc();
    s_disp();
    complete_run();
  end
endmodule

bind awc_top awc_chk #(.NUM_ALARM(NUM_ALARM), .NUM_WARN(NUM_WARN),
  .NOTIFY_LAG(NOTIFY_LAG)) awc_chk_i (.clk, .rst, .ext_alarm_clear_in,
  .alarm_cause_i, .comm_err_i, .map_req_i, .map_ack_o, .map_ok_o,
  .drive_state_o, .warn_o, .disp_num_o, .disp_hold_o, .clear_done_o,
  .led_run_o, .led_err_o, .esm_state_o, .al_status_o, .alarm_active_o,
  .al_notify_o);
`default_nettype wire

// >>> awc_top.sv
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module awc_top import awc_pkg::*; #(
  parameter int unsigned NUM_ALARM  = AWC_NUM_ALARM,
  parameter int unsigned NUM_WARN   = AWC_NUM_WARN,
  parameter int unsigned NOTIFY_LAG = AWC_NOTIFY_LAG
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          ext_alarm_clear_in,
  input  wire logic [NUM_ALARM-1:0]          alarm_cause_i,
  input  wire logic [NUM_ALARM-1:0]          alarm_unclr_i,
  input  wire logic [NUM_ALARM-1:0][7:0]     alarm_code_i,
  input  wire logic                          fault_react_done_i,
  input  wire logic [NUM_WARN-1:0]           warn_cause_i,
  input  wire awc_comm_err_t                 comm_err_i,
  input  wire logic                          pwr_reset_evt_i,
  input  wire logic                          esm_init_preop_i,
  input  wire logic                          esm_preop_safeop_i,
  input  wire awc_map_req_t                  map_req_i,
  output logic                               map_ack_o,
  output logic                               map_ok_o,
  output awc_state_t                         drive_state_o,
  output logic                               alarm_active_o,
  output logic [NUM_WARN-1:0]                warn_o,
  output logic [7:0]                         disp_num_o,
  output logic                               disp_hold_o,
  output logic                               clear_done_o,
  output logic                               led_run_o,
  output logic                               led_err_o,
  output logic [3:0]                         esm_state_o,
  output logic [15:0]                        al_status_o,
  output logic                               al_notify_o
);

  // ==========================================================
  // Parameter check
  generate
    if (NUM_ALARM < 1 || NUM_ALARM > 16 || NUM_WARN < 1 ||
        NUM_WARN > 16 || NOTIFY_LAG < 2) begin : g_bad_param
      $error("awc_top: unsupported parameter value");
    end
  endgenerate

  // ==========================================================
  // Bus decode
  logic        acc;
  logic        wr;
  logic        obj_hit;
  logic [7:0]  obj_ofs;
  logic [2:0]  obj_idx;
  logic        bus_err;
  logic        wr_ctrl;
  logic        wr_cword;
  logic        tool_clr;

  always_comb begin
    acc     = psel & penable;
    wr      = acc & pwrite;
    obj_ofs = paddr - AWC_OFS_OBJ;
    obj_hit = (paddr >= AWC_OFS_OBJ) && (paddr[1:0] == 2'h0) &&
              (obj_ofs[7:2] < 6'(AWC_NUM_OBJ));
    obj_idx = obj_ofs[4:2];
    bus_err = 1'b1;
    if (obj_hit) begin
      bus_err = pwrite && (AWC_OBJ_ATTR[obj_idx] == AWC_ATTR_X);
    end else begin
      case (paddr)
        AWC_OFS_CTRL, AWC_OFS_CWORD, AWC_OFS_TOOL: bus_err = 1'b0;
        AWC_OFS_STAT, AWC_OFS_ALARM, AWC_OFS_WARN, AWC_OFS_DISP,
        AWC_OFS_COMM: bus_err = pwrite;
        default: bus_err = 1'b1;
      endcase
    end
    wr_ctrl  = wr && (paddr == AWC_OFS_CTRL);
    wr_cword = wr && (paddr == AWC_OFS_CWORD);
    tool_clr = wr && (paddr == AWC_OFS_TOOL) && pwdata[AWC_TOOL_CLR_BIT];
  end

  assign pready  = 1'b1;
  assign pslverr = acc & bus_err;

  // ==========================================================
  // Control registers
  logic [1:0]  ctrl_q;
  logic [1:0]  ctrl_d;
  logic [15:0] cword_q;
  logic [15:0] cword_d;

  always_comb begin
    ctrl_d  = wr_ctrl  ? pwdata[1:0]  : ctrl_q;
    cword_d = wr_cword ? pwdata[15:0] : cword_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q  <= AWC_CTRL_RST;
      cword_q <= AWC_CWORD_RST;
    end else begin
      ctrl_q  <= ctrl_d;
      cword_q <= cword_d;
    end
  end

  // ==========================================================
  // Edge detection
  logic ext_lvl;
  logic ext_rise;
  logic cw_rise;

  awc_edge #(.SYNC(1'b1)) u_ext_edge (
    .clk   (clk),
    .rst   (rst),
    .din   (ext_alarm_clear_in),
    .level (ext_lvl),
    .rise  (ext_rise)
  );

  awc_edge #(.SYNC(1'b0)) u_cw_edge (
    .clk   (clk),
    .rst   (rst),
    .din   (cword_q[AWC_CW_FRESET_BIT]),
    .level (),
    .rise  (cw_rise)
  );

  // ==========================================================
  // Clear requests
  logic fb_req;
  logic alm_req;
  logic wrn_req;

  always_comb begin
    fb_req  = ctrl_q[AWC_CTRL_ACK_BIT] & cw_rise;
    alm_req = ext_rise | (~ext_lvl & (fb_req | tool_clr));
    wrn_req = ext_rise | (~ext_lvl & (cw_rise | tool_clr));
  end

  // ==========================================================
  // Alarm latch, display and drive state
  awc_state_t           state_q;
  awc_state_t           state_d;
  logic [NUM_ALARM-1:0] alarm_q;
  logic [NUM_ALARM-1:0] alarm_d;
  logic [7:0]           disp_q;
  logic [7:0]           disp_d;
  logic                 disp_vld_q;
  logic                 disp_vld_d;
  logic                 done_q;
  logic                 done_d;
  logic                 clr_ok;
  logic [NUM_ALARM-1:0] kept;
  logic [7:0]           first_code;

  always_comb begin
    first_code = 8'h00;
    for (int i = NUM_ALARM - 1; i >= 0; i--) begin
      if (alarm_cause_i[i]) begin
        first_code = alarm_code_i[i];
      end
    end
    clr_ok = alm_req && (state_q == AWC_ST_FAULT)
             && (alarm_cause_i == '0);
    kept       = alarm_q & alarm_unclr_i;
    alarm_d    = alarm_q | alarm_cause_i;
    state_d    = state_q;
    disp_d     = disp_q;
    disp_vld_d = disp_vld_q;
    done_d     = 1'b0;
    if (clr_ok) begin
      alarm_d = kept | alarm_cause_i;
      done_d  = 1'b1;
      if (kept == '0) begin
        disp_vld_d = 1'b0;
      end
    end
    if (!disp_vld_d && (alarm_cause_i != '0)) begin
      disp_d     = first_code;
      disp_vld_d = 1'b1;
    end
    case (state_q)
      AWC_ST_SOD: begin
        if (alarm_cause_i != '0) begin
          state_d = AWC_ST_FREACT;
        end
      end
      AWC_ST_FREACT: begin
        if (fault_react_done_i) begin
          state_d = AWC_ST_FAULT;
        end
      end
      AWC_ST_FAULT: begin
        if (clr_ok && kept == '0) begin
          state_d = AWC_ST_SOD;
        end
      end
      default: state_d = AWC_ST_SOD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= AWC_ST_SOD;
      alarm_q    <= '0;
      disp_q     <= 8'h00;
      disp_vld_q <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      alarm_q    <= alarm_d;
      disp_q     <= disp_d;
      disp_vld_q <= disp_vld_d;
      done_q     <= done_d;
    end
  end

  // ==========================================================
  // Warnings
  logic [NUM_WARN-1:0] warn_q;
  logic [NUM_WARN-1:0] warn_d;
  logic [NUM_WARN-1:0] warn_eff;

  always_comb begin
    warn_eff = ext_lvl ? '0 : warn_cause_i;
    if (!ctrl_q[AWC_CTRL_WLATCH_BIT]) begin
      warn_d = warn_eff;
    end else if (wrn_req && state_q != AWC_ST_FREACT) begin
      warn_d = warn_eff;
    end else begin
      warn_d = warn_q | warn_eff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      warn_q <= '0;
    end else begin
      warn_q <= warn_d;
    end
  end

  // ==========================================================
  // Communication status and delayed notification
  awc_comm_err_t       comm_q;
  awc_comm_err_t       comm_d;
  logic [NOTIFY_LAG-1:0] lag_q;
  logic [NOTIFY_LAG-1:0] lag_d;

  always_comb begin
    comm_d       = comm_err_i.valid ? comm_err_i : comm_q;
    comm_d.valid = 1'b0;
    lag_d = {lag_q[NOTIFY_LAG-2:0], (|alarm_q) | (|warn_q)};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      comm_q <= '0;
      lag_q  <= '0;
    end else begin
      comm_q <= comm_d;
      lag_q  <= lag_d;
    end
  end

  // ==========================================================
  // Objects with immediate or deferred effect
  logic [15:0] obj_q  [AWC_NUM_OBJ];
  logic [15:0] pend_q [AWC_NUM_OBJ];
  logic        pv_q   [AWC_NUM_OBJ];

  generate
    for (genvar g = 0; g < AWC_NUM_OBJ; g++) begin : g_obj
      logic        hit;
      logic        evt;
      logic [15:0] val_d;
      logic [15:0] pnd_d;
      logic        pv_d;
      always_comb begin
        hit = wr && obj_hit && (obj_idx == 3'(g));
        case (AWC_OBJ_ATTR[g])
          AWC_ATTR_R: evt = pwr_reset_evt_i;
          AWC_ATTR_P: evt = esm_init_preop_i;
          AWC_ATTR_S: evt = esm_preop_safeop_i;
          default:    evt = 1'b0;
        endcase
        val_d = obj_q[g];
        pnd_d = pend_q[g];
        pv_d  = pv_q[g];
        if (evt && pv_q[g]) begin
          val_d = pend_q[g];
          pv_d  = 1'b0;
        end
        if (hit && AWC_OBJ_ATTR[g] == AWC_ATTR_A) begin
          val_d = pwdata[15:0];
        end else if (hit && AWC_OBJ_ATTR[g] != AWC_ATTR_X) begin
          pnd_d = pwdata[15:0];
          pv_d  = 1'b1;
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          obj_q[g]  <= AWC_OBJ_RST;
          pend_q[g] <= AWC_OBJ_RST;
          pv_q[g]   <= 1'b0;
        end else begin
          obj_q[g]  <= val_d;
          pend_q[g] <= pnd_d;
          pv_q[g]   <= pv_d;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Mapping check and read data
  logic        map_ack_q;
  logic        map_ack_d;
  logic        map_ok_q;
  logic        map_ok_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  always_comb begin
    map_ack_d = map_req_i.valid;
    map_ok_d  = 1'b0;
    if (map_req_i.valid && map_req_i.idx < 3'(AWC_NUM_OBJ)) begin
      map_ok_d = AWC_OBJ_PDO[map_req_i.idx][map_req_i.tx];
    end
    prdata_d = prdata_q;
    if (psel && !penable) begin
      prdata_d = 32'h0000_0000;
      if (obj_hit) begin
        prdata_d = {16'h0000, obj_q[obj_idx]};
      end else begin
        case (paddr)
          AWC_OFS_CTRL:  prdata_d = {30'h0, ctrl_q};
          AWC_OFS_CWORD: prdata_d = {16'h0000, cword_q};
          AWC_OFS_STAT:  prdata_d = {27'h0, ext_lvl, lag_q[NOTIFY_LAG-1],
                                     |alarm_q, state_q};
          AWC_OFS_ALARM: prdata_d = 32'(alarm_q);
          AWC_OFS_WARN:  prdata_d = 32'(warn_q);
          AWC_OFS_DISP:  prdata_d = {23'h0, disp_vld_q, disp_q};
          AWC_OFS_COMM:  prdata_d = {9'h0, comm_q.run_led, comm_q.err_led,
                                     comm_q.esm, 1'b0, comm_q.al_status};
          default:       prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      map_ack_q <= 1'b0;
      map_ok_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      map_ack_q <= map_ack_d;
      map_ok_q  <= map_ok_d;
      prdata_q  <= prdata_d;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata         = prdata_q;
  assign map_ack_o      = map_ack_q;
  assign map_ok_o       = map_ok_q;
  assign drive_state_o  = state_q;
  assign alarm_active_o = |alarm_q;
  assign warn_o         = warn_q;
  assign disp_num_o     = disp_q;
  assign disp_hold_o    = disp_vld_q;
  assign clear_done_o   = done_q;
  assign led_run_o      = comm_q.run_led;
  assign led_err_o      = comm_q.err_led;
  assign esm_state_o    = comm_q.esm;
  assign al_status_o    = comm_q.al_status;
  assign al_notify_o    = lag_q[NOTIFY_LAG-1];

endmodule
`default_nettype wire
